/* rtl/fe_cfg_defs.svh */
`ifndef FE_CFG_DEFS_SVH
`define FE_CFG_DEFS_SVH
// register bus byte offsets
`define ADDR_SHADOW_SEL 8'h00
`define ADDR_NIBBLE 8'h04
`define ADDR_DC_LO 8'h08
`define ADDR_DC_HI 8'h0c
`define ADDR_FE_CTRL 8'h10
`define ADDR_DECODE 8'h14
// shadow register addresses written into the select register
`define SHADOW_DC 4'h7
`define SHADOW_FE 4'ha
// nibbles per multiple write
`define DC_NIBBLES 9
`define FE_NIBBLES 4
// reset values
`define DC_RESET 36'h000000000
`define FE_RESET 16'h0000
// offset field positions
`define OFS_W 6
`define DIODE_A_LSB 0
`define DIODE_B_LSB 6
`define DIODE_C_LSB 12
`define DIODE_D_LSB 18
`define RADIAL_A_LSB 24
`define RADIAL_B_LSB 30
// front-end control field positions
`define GAIN_LSB 0
`define SLEW_LSB 4
`define EQ_LSB 8
`define HP_LSB 10
// tracking current end points in microamperes
`define SLEW_MIN_UA 8'h0a
`define SLEW_MAX_UA 8'hb4
`endif

/* rtl/fe_cfg_pkg.sv */
package fe_cfg_pkg;
	// multiple-write loader states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DC = 3'b010,
		ST_FE = 3'b100
	} load_state_e;
	// equaliser speed codes
	typedef enum logic [1:0] {
		EQ_1X = 2'b00,
		EQ_2X = 2'b01,
		EQ_4X = 2'b10,
		EQ_RSVD = 2'b11
	} eq_speed_e;
endpackage : fe_cfg_pkg

/* rtl/nibble_collect.sv */
`timescale 1ns/100ps
`default_nettype none
module nibble_collect #(
	parameter int NIBBLES = 9,
	parameter int CW = $clog2(NIBBLES + 1)
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic nib_valid,
	input wire logic [3:0] nib_data,
	output logic [NIBBLES*4-1:0] word,
	output logic [CW-1:0] count,
	output logic done
);
	localparam int W = NIBBLES * 4;
	generate
		if (NIBBLES < 2 || NIBBLES > 15 || CW < $clog2(NIBBLES)) begin : g_bad
			$error("nibble_collect: NIBBLES 2..15, CW wide enough to count");
		end
	endgenerate

	logic [W-1:0] acc_q, acc_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic done_q, done_d;

	// first nibble ends at the top, the last one in bits 3:0
	always_comb begin
		acc_d = acc_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (clear) begin
			cnt_d = '0;
		end else if (nib_valid) begin
			acc_d = {acc_q[W-5:0], nib_data};
			if (cnt_q == CW'(NIBBLES - 1)) begin
				cnt_d = '0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q + CW'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			acc_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign word = acc_q;
	assign count = cnt_q;
	assign done = done_q;
endmodule : nibble_collect
`default_nettype wire

/* rtl/frontend_offset_gain_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fe_cfg_defs.svh"
module frontend_offset_gain_config_regs #(
	parameter int AW = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [AW-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic [5:0] diode_a_offset,
	output logic [5:0] diode_b_offset,
	output logic [5:0] diode_c_offset,
	output logic [5:0] diode_d_offset,
	output logic [5:0] radial_a_offset,
	output logic [5:0] radial_b_offset,
	output logic [3:0] highfreq_gain_code,
	output logic [3:0] gain_level,
	output logic [10:0] gain_mv,
	output logic [3:0] slicer_slew_code,
	output logic [7:0] threshold_tracking_current,
	output logic [1:0] equaliser_speed_select,
	output logic [2:0] eq_speed_onehot,
	output logic eq_speed_reserved,
	output logic [5:0] highpass_cutoff_code,
	output logic [5:0] highpass_band_khz,
	output logic [2:0] highpass_trim_step,
	output logic highpass_trim_reserved
);
	generate
		if (AW < 5) begin : g_bad
			$error("frontend_offset_gain_config_regs: AW must be >= 5");
		end
	endgenerate

	localparam int DCW = `DC_NIBBLES * 4;
	localparam int FEW = `FE_NIBBLES * 4;

	// every check below runs on the one clock and sleeps through reset, except AST_RESET_ZERO, which stays active in reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// gain code to millivolt level
	function automatic logic [10:0] gain_mv_f(input logic [3:0] c);
		logic [10:0] v;
		v = 11'h000;
		unique case (c)
			4'h0, 4'h4: v = 11'h456;
			4'h1, 4'h5: v = 11'h3b8;
			4'h2, 4'h6: v = 11'h24c;
			4'h3, 4'h7: v = 11'h188;
			4'h8: v = 11'h12f;
			4'h9: v = 11'h0c8;
			4'ha: v = 11'h09d;
			4'hb: v = 11'h06b;
			4'hc: v = 11'h04f;
			4'hd: v = 11'h036;
			4'he: v = 11'h027;
			4'hf: v = 11'h01b;
		endcase
		return v;
	endfunction : gain_mv_f

	// slew code to tracking current in microamperes
	function automatic logic [7:0] slew_ua_f(input logic [3:0] c);
		logic [7:0] v;
		v = 8'h00;
		unique case (c)
			4'h0, 4'h1: v = `SLEW_MIN_UA;
			4'h2: v = 8'h14;
			4'h3: v = 8'h1e;
			4'h4: v = 8'h32;
			4'h5: v = 8'h3c;
			4'h6: v = 8'h46;
			4'h7: v = 8'h50;
			4'h8: v = 8'h64;
			4'h9: v = 8'h6e;
			4'ha: v = 8'h78;
			4'hb: v = 8'h82;
			4'hc: v = 8'h96;
			4'hd: v = 8'ha0;
			4'he: v = 8'haa;
			4'hf: v = `SLEW_MAX_UA;
		endcase
		return v;
	endfunction : slew_ua_f

	fe_cfg_pkg::load_state_e state_q, state_d;
	logic sel_wr, nib_wr, dc_valid, fe_valid;
	logic [DCW-1:0] dc_word;
	logic [FEW-1:0] fe_word;
	logic [3:0] dc_count, fe_count;
	logic dc_done, fe_done;

	assign sel_wr = wr && (addr == AW'(`ADDR_SHADOW_SEL));
	assign nib_wr = wr && (addr == AW'(`ADDR_NIBBLE));
	// nibbles outside a started multiple write are dropped
	assign dc_valid = nib_wr && (state_q == fe_cfg_pkg::ST_DC);
	assign fe_valid = nib_wr && (state_q == fe_cfg_pkg::ST_FE);

	// loader: a select write starts a fresh sequence, the last nibble ends it
	always_comb begin
		state_d = state_q;
		if (sel_wr) begin
			if (wdata[3:0] == `SHADOW_DC)
				state_d = fe_cfg_pkg::ST_DC;
			else if (wdata[3:0] == `SHADOW_FE)
				state_d = fe_cfg_pkg::ST_FE;
			else
				state_d = fe_cfg_pkg::ST_IDLE;
		end else begin
			unique case (state_q)
				fe_cfg_pkg::ST_IDLE: state_d = fe_cfg_pkg::ST_IDLE;
				fe_cfg_pkg::ST_DC: begin
					if (dc_valid && dc_count == 4'(`DC_NIBBLES - 1))
						state_d = fe_cfg_pkg::ST_IDLE;
				end
				fe_cfg_pkg::ST_FE: begin
					if (fe_valid && fe_count == 4'(`FE_NIBBLES - 1))
						state_d = fe_cfg_pkg::ST_IDLE;
				end
				default: state_d = fe_cfg_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			state_q <= fe_cfg_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	// radial b arrives first and lands in the top nibble
	nibble_collect #(.NIBBLES(`DC_NIBBLES), .CW(4)) u_dc_collect (
		.clock(clock),
		.rst_n(rst_n),
		.clear(sel_wr),
		.nib_valid(dc_valid),
		.nib_data(wdata[3:0]),
		.word(dc_word),
		.count(dc_count),
		.done(dc_done)
	);

	nibble_collect #(.NIBBLES(`FE_NIBBLES), .CW(4)) u_fe_collect (
		.clock(clock),
		.rst_n(rst_n),
		.clear(sel_wr),
		.nib_valid(fe_valid),
		.nib_data(wdata[3:0]),
		.word(fe_word),
		.count(fe_count),
		.done(fe_done)
	);

	// shadows change only on a complete load, never half-written
	logic [DCW-1:0] dc_q, dc_d;
	logic [FEW-1:0] fe_q, fe_d;
	always_comb begin
		dc_d = dc_done ? dc_word : dc_q;
		fe_d = fe_done ? fe_word : fe_q;
	end

	// decode from the next value so settings align with the shadow
	logic [3:0] gl_d, gl_q;
	logic [10:0] gmv_d, gmv_q;
	logic [7:0] cur_d, cur_q;
	logic [2:0] eqh_d, eqh_q;
	logic eqr_d, eqr_q;
	logic [5:0] band_d, band_q;
	logic [2:0] trim_d, trim_q;
	logic trr_d, trr_q;
	logic [3:0] g_c, s_c;
	logic [1:0] e_c;
	logic [5:0] h_c;
	always_comb begin
		g_c = fe_d[`GAIN_LSB +: 4];
		s_c = fe_d[`SLEW_LSB +: 4];
		e_c = fe_d[`EQ_LSB +: 2];
		h_c = fe_d[`HP_LSB +: 6];
		// bit 2 only counts once bit 3 is set
		if (g_c[3])
			gl_d = 4'h4 + {1'b0, g_c[2:0]};
		else
			gl_d = {2'b00, g_c[1:0]};
		gmv_d = gain_mv_f(g_c);
		cur_d = slew_ua_f(s_c);
		eqr_d = 1'b0;
		unique case (e_c)
			fe_cfg_pkg::EQ_1X: eqh_d = 3'b001;
			fe_cfg_pkg::EQ_2X: eqh_d = 3'b010;
			fe_cfg_pkg::EQ_4X: eqh_d = 3'b100;
			// reserved code keeps the equaliser at single speed
			fe_cfg_pkg::EQ_RSVD: begin
				eqh_d = 3'b001;
				eqr_d = 1'b1;
			end
		endcase
		unique case (h_c[1:0])
			2'b00: band_d = 6'h0a;
			2'b10: band_d = 6'h14;
			2'b01: band_d = 6'h1e;
			2'b11: band_d = 6'h28;
		endcase
		// step 0 is -37.5 percent, step 6 is +18 percent
		trim_d = {h_c[2], h_c[3], h_c[4]};
		trr_d = h_c[5] || (&h_c[4:2]);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dc_q <= `DC_RESET;
			fe_q <= `FE_RESET;
			gl_q <= 4'h0;
			gmv_q <= 11'h456;
			cur_q <= `SLEW_MIN_UA;
			eqh_q <= 3'b001;
			eqr_q <= 1'b0;
			band_q <= 6'h0a;
			trim_q <= 3'h0;
			trr_q <= 1'b0;
		end else begin
			dc_q <= dc_d;
			fe_q <= fe_d;
			gl_q <= gl_d;
			gmv_q <= gmv_d;
			cur_q <= cur_d;
			eqh_q <= eqh_d;
			eqr_q <= eqr_d;
			band_q <= band_d;
			trim_q <= trim_d;
			trr_q <= trr_d;
		end
	end

	// field slices of the shadows
	assign diode_a_offset = dc_q[`DIODE_A_LSB +: `OFS_W];
	assign diode_b_offset = dc_q[`DIODE_B_LSB +: `OFS_W];
	assign diode_c_offset = dc_q[`DIODE_C_LSB +: `OFS_W];
	assign diode_d_offset = dc_q[`DIODE_D_LSB +: `OFS_W];
	assign radial_a_offset = dc_q[`RADIAL_A_LSB +: `OFS_W];
	assign radial_b_offset = dc_q[`RADIAL_B_LSB +: `OFS_W];
	assign highfreq_gain_code = fe_q[`GAIN_LSB +: 4];
	assign slicer_slew_code = fe_q[`SLEW_LSB +: 4];
	assign equaliser_speed_select = fe_q[`EQ_LSB +: 2];
	assign highpass_cutoff_code = fe_q[`HP_LSB +: 6];
	assign gain_level = gl_q;
	assign gain_mv = gmv_q;
	assign threshold_tracking_current = cur_q;
	assign eq_speed_onehot = eqh_q;
	assign eq_speed_reserved = eqr_q;
	assign highpass_band_khz = band_q;
	assign highpass_trim_step = trim_q;
	assign highpass_trim_reserved = trr_q;

	// read mux; unmapped offsets and writes-only cycles return zero
	logic [31:0] rdata_q, rdata_d;
	logic [3:0] act_count;
	always_comb begin
		act_count = (state_q == fe_cfg_pkg::ST_FE) ? fe_count : dc_count;
		rdata_d = 32'h00000000;
		if (rd) begin
			unique case (addr)
				AW'(`ADDR_SHADOW_SEL):
					rdata_d = {20'h00000, act_count, 5'h00, state_q};
				AW'(`ADDR_DC_LO): rdata_d = dc_q[31:0];
				AW'(`ADDR_DC_HI): rdata_d = {28'h0000000, dc_q[35:32]};
				AW'(`ADDR_FE_CTRL): rdata_d = {16'h0000, fe_q};
				AW'(`ADDR_DECODE):
					rdata_d = {2'b00, trr_q, trim_q, band_q, eqr_q,
						eqh_q, cur_q, 4'h0, gl_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			rdata_q <= 32'h00000000;
		else
			rdata_q <= rdata_d;
	end
	assign rdata = rdata_q;

	sequence s_last_dc_nib;
		dc_valid && dc_count == 4'(`DC_NIBBLES - 1);
	endsequence
	sequence s_dc_committed;
		##2 (dc_q[3:0] == $past(wdata[3:0], 2));
	endsequence

	AST_DIODE_READ: assert property (
		rd && addr == AW'(`ADDR_DC_LO) |=> rdata[11:0] ==
			{$past(diode_b_offset), $past(diode_a_offset)})
		else $error("diode offsets misplaced in offset register");
	AST_RADIAL_READ: assert property (
		rd && addr == AW'(`ADDR_DC_HI) |=>
			rdata[3:0] == $past(radial_b_offset[5:2]) && rdata[31:4] == 0)
		else $error("radial offsets misplaced in offset register");
	AST_RESET_ZERO: assert property (disable iff (1'b0)
		!rst_n |=> diode_a_offset == 0 && diode_d_offset == 0 &&
			radial_a_offset == 0 && radial_b_offset == 0)
		else $error("offset fields not cleared by reset");
	AST_FE_FIELDS: assert property (
		fe_done |=> highfreq_gain_code == $past(fe_word[3:0]) &&
			highpass_cutoff_code == $past(fe_word[15:10]))
		else $error("front-end control fields misplaced");
	AST_EQ_DECODE: assert property (
		equaliser_speed_select != 2'b11 |->
			eq_speed_onehot == (3'b001 << equaliser_speed_select))
		else $error("equaliser speed decoded wrongly");
	AST_GAIN_FOLD: assert property (
		!highfreq_gain_code[3] |-> gain_level == {2'b00,
			highfreq_gain_code[1:0]} && gain_mv >= 11'h188)
		else $error("gain bit 2 not ignored");
	AST_GAIN_LOW: assert property (
		highfreq_gain_code[3] |-> gain_mv < 11'h188 &&
			gain_level == 4'h4 + {1'b0, highfreq_gain_code[2:0]})
		else $error("low gain levels wrong");
	AST_SLEW_ENDS: assert property (
		slicer_slew_code <= 4'h1 && threshold_tracking_current ==
			`SLEW_MIN_UA || slicer_slew_code == 4'hf &&
			threshold_tracking_current == `SLEW_MAX_UA ||
			slicer_slew_code inside {[4'h2:4'he]})
		else $error("tracking current end points wrong");
	AST_HP_BAND: assert property (
		highpass_band_khz == 6'h0a + 6'h0a * {4'h0,
			highpass_cutoff_code[0], highpass_cutoff_code[1]})
		else $error("high-pass band wrong");
	AST_HP_TRIM: assert property (
		highpass_trim_step == {highpass_cutoff_code[2],
			highpass_cutoff_code[3], highpass_cutoff_code[4]})
		else $error("high-pass trim step wrong");
	AST_NINE_NIBBLES: assert property (
		s_last_dc_nib |-> s_dc_committed ##0
			state_q == fe_cfg_pkg::ST_IDLE)
		else $error("offset register not loaded by nine nibbles");
endmodule : frontend_offset_gain_config_regs
`default_nettype wire

/* tb/mcu_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fe_cfg_defs.svh"
// stands in for the external controller loading the shadow registers
module mcu_model (
	input wire logic clock,
	input wire logic [31:0] rdata,
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd
);
	// idle bus from time zero
	initial begin
		addr = 8'h00;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one-cycle write strobe, one idle cycle after it
	task automatic write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		wdata <= ~d; // stale data must not be taken
	endtask : write

	// data taken mid-cycle after the strobe, clear of the edge race
	task automatic read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask : read

	// select the shadow register, then nibbles most significant first
	task automatic load(input logic [3:0] sel, input logic [35:0] v,
		input int n);
		write(`ADDR_SHADOW_SEL, {28'h0000000, sel});
		for (int i = n - 1; i >= 0; i--) begin
			write(`ADDR_NIBBLE, {28'h0000000, v[i*4 +: 4]});
		end
	endtask : load
endmodule : mcu_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fe_cfg_defs.svh"
`define CHK(nm, exp, got) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("[FAIL] %s expected %h seen %h", nm, exp, got); \
	end \
end
module tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, rv;
	logic wr, rd;
	logic [5:0] ofs [0:5];
	logic [3:0] highfreq_gain_code, gain_level, slicer_slew_code, c;
	logic [10:0] gain_mv;
	logic [7:0] threshold_tracking_current;
	logic [1:0] equaliser_speed_select;
	logic [2:0] eq_speed_onehot, highpass_trim_step;
	logic eq_speed_reserved, highpass_trim_reserved;
	logic [5:0] highpass_cutoff_code, highpass_band_khz, hp;
	logic [35:0] dc_v = 36'h9a5c3e1f7;
	logic [15:0] fe_v, fe_seen;
	logic [3:0] exp_level;
	logic [2:0] exp_hot;
	int mismatches = 0;
	int samples_checked = 0;
	// expected levels per code
	logic [10:0] mv_t [0:15] = '{11'h456, 11'h3b8, 11'h24c, 11'h188,
		11'h456, 11'h3b8, 11'h24c, 11'h188, 11'h12f, 11'h0c8, 11'h09d,
		11'h06b, 11'h04f, 11'h036, 11'h027, 11'h01b};
	logic [7:0] ua_t [0:15] = '{8'h0a, 8'h0a, 8'h14, 8'h1e, 8'h32, 8'h3c,
		8'h46, 8'h50, 8'h64, 8'h6e, 8'h78, 8'h82, 8'h96, 8'ha0, 8'haa, 8'hb4};
	logic [5:0] band_t [0:3] = '{6'h0a, 6'h1e, 6'h14, 6'h28};
	// trim step per high-pass code bits 4:2, seven steps then reserved
	logic [2:0] trim_t [0:7] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h5, 3'h3,
		3'h7};

	always #50 clock = ~clock;

	// front-end fields as one word, kept out of macro arguments
	assign fe_seen = {highpass_cutoff_code, equaliser_speed_select,
		slicer_slew_code, highfreq_gain_code};

	frontend_offset_gain_config_regs frontend_offset_gain_config_regs_i (
		.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata),
		.diode_a_offset(ofs[0]), .diode_b_offset(ofs[1]),
		.diode_c_offset(ofs[2]), .diode_d_offset(ofs[3]),
		.radial_a_offset(ofs[4]), .radial_b_offset(ofs[5]),
		.highfreq_gain_code(highfreq_gain_code), .gain_level(gain_level),
		.gain_mv(gain_mv), .slicer_slew_code(slicer_slew_code),
		.threshold_tracking_current(threshold_tracking_current),
		.equaliser_speed_select(equaliser_speed_select),
		.eq_speed_onehot(eq_speed_onehot),
		.eq_speed_reserved(eq_speed_reserved),
		.highpass_cutoff_code(highpass_cutoff_code),
		.highpass_band_khz(highpass_band_khz),
		.highpass_trim_step(highpass_trim_step),
		.highpass_trim_reserved(highpass_trim_reserved)
	);

	mcu_model mcu_model_i (
		.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd)
	);

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// committed values land two edges after the last nibble
	task automatic settle();
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask : settle

	// cut a hang short; the full run needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		for (int k = 0; k < 6; k++) `CHK("offset_rst", 6'h00, ofs[k])
		mcu_model_i.read(`ADDR_DECODE, rv);
		`CHK("decode_rst", 32'h00a10a00, rv)
		// full offset load, every field distinct
		mcu_model_i.load(`SHADOW_DC, dc_v, `DC_NIBBLES);
		settle();
		for (int k = 0; k < 6; k++) begin
			`CHK("offset", dc_v[k*6 +: 6], ofs[k])
		end
		mcu_model_i.read(`ADDR_DC_LO, rv);
		`CHK("dc_lo", dc_v[31:0], rv)
		mcu_model_i.read(`ADDR_DC_HI, rv);
		`CHK("dc_hi", 32'(dc_v[35:32]), rv)
		// aborted load, then nibbles while idle: nothing may commit
		mcu_model_i.load(`SHADOW_DC, 36'h000000000, 3);
		// status: three nibbles counted, loader in the offset state
		mcu_model_i.read(`ADDR_SHADOW_SEL, rv);
		`CHK("status_part", 32'h00000302, rv)
		mcu_model_i.load(4'h0, 36'hfffffffff, 6);
		settle();
		mcu_model_i.read(`ADDR_SHADOW_SEL, rv);
		`CHK("status_idle", 32'h00000001, rv)
		for (int k = 0; k < 6; k++) begin
			`CHK("offset_kept", dc_v[k*6 +: 6], ofs[k])
		end
		mcu_model_i.read(8'h20, rv);
		`CHK("unmapped", 32'h00000000, rv)
		mcu_model_i.read(`ADDR_NIBBLE, rv);
		`CHK("nibble_rd", 32'h00000000, rv)
		// every gain, slew, speed and band code, trims stepping along
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			hp = {c, c[1:0]};
			fe_v = {hp, c[1:0], c, c};
			mcu_model_i.load(`SHADOW_FE, 36'(fe_v), `FE_NIBBLES);
			settle();
			`CHK("fe_fields", fe_v, fe_seen)
			`CHK("gain_mv", mv_t[i], gain_mv)
			exp_level = c[3] ? c - 4'h4 : 4'(c[1:0]);
			`CHK("gain_level", exp_level, gain_level)
			`CHK("current", ua_t[i], threshold_tracking_current)
			exp_hot = (c[1:0] == 2'b11) ? 3'b001 : 3'b001 << c[1:0];
			`CHK("eq_onehot", exp_hot, eq_speed_onehot)
			`CHK("eq_rsvd", c[1:0] == 2'b11, eq_speed_reserved)
			`CHK("band", band_t[c[1:0]], highpass_band_khz)
			`CHK("trim_rsvd", c[3] | &c[2:0], highpass_trim_reserved)
			if (!c[3]) `CHK("trim", trim_t[c[2:0]], highpass_trim_step)
		end
		mcu_model_i.read(`ADDR_FE_CTRL, rv);
		`CHK("fe_rd", 32'(fe_v), rv)
		// second reset in mid-run clears the offsets again
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		for (int k = 0; k < 6; k++) `CHK("offset_rst2", 6'h00, ofs[k])
		`CHK("eq_rst", 2'b00, equaliser_speed_select)
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
